// ==== hdl/windowed_watchdog_clock_monitor.sv ====
// windowed watchdog with clock monitor, idle timer and register port
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - after reset watchdog and clock monitor on, longest window selected
// - window select and monitor enable change only on first service, then lock
// - first service with wrong key raises a watchdog fault
// - later services must match window, key and monitor enable exactly
// - reads of the service register show zero in the key field
// - timeout detector held still during halt and idle
// - clock monitor keeps running in halt and idle, flags stopped clock
// - clock monitor error pulls the shared fault pin low
// - leaving halt restarts the window; software waits lower limit first
// - idle counter is not cleared by the ordinary reset
// - pending flag set on each selected tap toggle; software clears it
// - leaving idle is an automatic service; software waits lower limit
// - first service accepted anywhere, even inside the lower limit
// - boot exit services and lets the next service come at any time
// - service byte is select[7:6], key[5:1], monitor enable[0]
// - upper limit 8k, 16k, 32k or 64k clocks; lower limit 2048
// - fault held 16 to 32 cycles after pin low; services then ignored
module windowed_watchdog_clock_monitor
   import wdt_pkg::*;
#(
   parameter int CM_LIMIT = CM_CYCLES
) (
   // clock and resets
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      por_i,
   // register port
   input  wire logic [wdt_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [wdt_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                      wr_i,
   input  wire logic                      rd_i,
   output logic      [wdt_pkg::DATA_W-1:0] rdata_o,
   // power modes and boot flow
   input  wire logic                      halt_i,
   input  wire logic                      idle_i,
   input  wire logic                      boot_entry_i,
   input  wire logic                      boot_exit_i,
   // tick time base and clock under watch
   input  wire logic                      tick_i,
   input  wire logic                      inst_clk_i,
   // fault pin, open drain
   input  wire logic                      fault_pin_i,
   output logic                           fault_pin_o,
   output logic                           fault_pin_oe_o,
   // idle timer flag
   output logic                           idle_tick_pending_o
);
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   localparam int CM_W = $clog2(CM_LIMIT + 1);

   function automatic logic [WIN_W-1:0] upper_lim(input logic [1:0] sel);
      upper_lim = UPPER_BASE << sel;
   endfunction

   function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      is_addr = (a == off);
   endfunction

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   logic [1:0]       sel_q;
   logic             cm_en_q;
   logic             first_done_q;
   logic             lower_en_q;
   logic [WIN_W-1:0] win_cnt_q;
   logic             halt_q;
   logic             idle_q;
   logic             busy_q;
   logic             err_q;
   logic [2:0]       tap_q;
   logic             inst_q;
   logic [CM_W-1:0]  cm_cnt_q;
   logic             cm_err_q;
   logic             pend;

   fault_if f ();

   // ----------------------------------------------------------
   // decode
   // ----------------------------------------------------------
   logic svc_wr;
   logic idl_wr;
   logic key_ok;
   logic full_ok;
   logic early;
   logic svc_take;
   logic svc_err;
   logic svc_ok;
   logic wd_run;
   logic timeout;
   logic halt_exit;
   logic idle_exit;
   logic busy_fall;
   logic restart;

   assign svc_wr    = wr_i && is_addr(addr_i, OFF_SERVICE);
   assign idl_wr    = wr_i && is_addr(addr_i, OFF_IDLE_CTL);
   assign key_ok    = (wdata_i[SVC_KEY_HI:SVC_KEY_LO] == SVC_KEY);
   assign full_ok   = key_ok
                      && (wdata_i[SVC_SEL_HI:SVC_SEL_LO] == sel_q)
                      && (wdata_i[SVC_CM] == cm_en_q);
   assign early     = lower_en_q && (win_cnt_q < LOWER_LIM);
   assign svc_take  = svc_wr && !f.busy;
   // first write is checked on key only, later on every field
   assign svc_err   = svc_take && (first_done_q ? (!full_ok || early) : !key_ok);
   assign svc_ok    = svc_take && !svc_err;
   assign wd_run    = !halt_i && !idle_i && !f.busy;
   assign timeout   = wd_run && tick_i && (win_cnt_q == upper_lim(sel_q) - 17'h0_0001);
   assign halt_exit = halt_q && !halt_i;
   assign idle_exit = idle_q && !idle_i;
   assign busy_fall = busy_q && !f.busy;
   assign restart   = svc_ok || halt_exit || idle_exit || boot_entry_i || boot_exit_i || busy_fall;

   // ----------------------------------------------------------
   // mode edge trackers
   // ----------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         halt_q <= 1'b0;
         idle_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         halt_q <= halt_i;
         idle_q <= idle_i;
         busy_q <= f.busy;
      end
   end

   // ----------------------------------------------------------
   // locked service value
   // ----------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_q        <= SEL_RST;
         cm_en_q      <= CM_EN_RST;
         first_done_q <= 1'b0;
      end else if (svc_ok && !first_done_q) begin
         sel_q        <= wdata_i[SVC_SEL_HI:SVC_SEL_LO];
         cm_en_q      <= wdata_i[SVC_CM];
         first_done_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------
   // lower window enable
   // ----------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lower_en_q <= 1'b0;
      end else if (boot_entry_i || boot_exit_i) begin
         lower_en_q <= 1'b0;
      end else if (svc_ok || halt_exit || idle_exit) begin
         // a restart after halt or idle must not be followed too soon
         lower_en_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------
   // service window counter, in idle timer clocks
   // ----------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         win_cnt_q <= '0;
      end else if (restart || f.busy) begin
         win_cnt_q <= '0;
      end else if (wd_run && tick_i) begin
         win_cnt_q <= win_cnt_q + 17'h0_0001;
      end
   end

   // ----------------------------------------------------------
   // watchdog error pulse to the pin stretcher
   // ----------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err_q <= 1'b0;
      end else begin
         err_q <= svc_err || timeout;
      end
   end

   // ----------------------------------------------------------
   // clock monitor
   // ----------------------------------------------------------
   // no gating by halt or idle: a stopped clock there is a real error
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         inst_q   <= 1'b0;
         cm_cnt_q <= '0;
      end else begin
         inst_q <= inst_clk_i;
         if (inst_clk_i != inst_q) begin
            cm_cnt_q <= '0;
         end else if (cm_cnt_q != CM_W'(CM_LIMIT)) begin
            cm_cnt_q <= cm_cnt_q + {{(CM_W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cm_err_q <= 1'b0;
      end else begin
         cm_err_q <= cm_en_q && (cm_cnt_q == CM_W'(CM_LIMIT));
      end
   end

   // ----------------------------------------------------------
   // fault pin
   // ----------------------------------------------------------
   assign f.err_p  = err_q;
   assign f.cm_err = cm_err_q;
   assign f.pin_in = fault_pin_i;

   fault_stretch u_stretch (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .f     (f)
   );

   assign fault_pin_oe_o = f.drive;

   // open drain: the driven level is always low
   always_ff @(posedge clk_i) begin
      fault_pin_o <= 1'b0;
   end

   // ----------------------------------------------------------
   // idle timer
   // ----------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tap_q <= TAP_RST;
      end else if (idl_wr) begin
         tap_q <= wdata_i[2:0];
      end
   end

   idle_tick_timer u_idle (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .por_i  (por_i),
      .tick_i (tick_i),
      .tap_i  (tap_q),
      .clr_i  (idl_wr && wdata_i[IDL_PEND_BIT]),
      .pend_o (pend)
   );

   assign idle_tick_pending_o = pend;

   // ----------------------------------------------------------
   // read port
   // ----------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         unique case (addr_i)
            OFF_SERVICE:  rdata_o <= {sel_q, 5'h00, cm_en_q};
            OFF_IDLE_CTL: rdata_o <= {pend, 4'h0, tap_q};
            OFF_STATUS:   rdata_o <= {4'h0, lower_en_q, cm_err_q, first_done_q, f.busy};
            default:      rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end
endmodule
`default_nettype wire

// ==== common/wdt_pkg.sv ====
// constants shared by the windowed watchdog and clock monitor
`default_nettype none
package wdt_pkg;
   // ----------------------------------------------------------
   // register map
   // ----------------------------------------------------------
   localparam int          ADDR_W       = 4;
   localparam int          DATA_W       = 8;
   localparam logic [3:0]  OFF_SERVICE  = 4'h0;
   localparam logic [3:0]  OFF_IDLE_CTL = 4'h1;
   localparam logic [3:0]  OFF_STATUS   = 4'h2;
   // ----------------------------------------------------------
   // service register fields and reset values
   // ----------------------------------------------------------
   localparam int          SVC_SEL_HI   = 7;
   localparam int          SVC_SEL_LO   = 6;
   localparam int          SVC_KEY_HI   = 5;
   localparam int          SVC_KEY_LO   = 1;
   localparam int          SVC_CM       = 0;
   localparam logic [4:0]  SVC_KEY      = 5'h0C;
   localparam logic [1:0]  SEL_RST      = 2'h3;
   localparam logic        CM_EN_RST    = 1'b1;
   // ----------------------------------------------------------
   // idle timer control fields
   // ----------------------------------------------------------
   localparam int          IDL_PEND_BIT = 7;
   localparam logic [2:0]  TAP_RST      = 3'h0;
   localparam logic [2:0]  TAP_MAX      = 3'h4;
   localparam int          TAP_BASE     = 12;
   localparam int          IDL_CNT_W    = 17;
   // ----------------------------------------------------------
   // status fields
   // ----------------------------------------------------------
   localparam int          ST_BUSY      = 0;
   localparam int          ST_FIRST     = 1;
   localparam int          ST_CM_ERR    = 2;
   localparam int          ST_LOWER     = 3;
   // ----------------------------------------------------------
   // window limits and timing
   // ----------------------------------------------------------
   localparam int          WIN_W        = 17;
   localparam logic [16:0] LOWER_LIM    = 17'h0_0800;
   localparam logic [16:0] UPPER_BASE   = 17'h0_2000;
   localparam logic [4:0]  FAULT_HOLD   = 5'h18;
   localparam int          CLK_MHZ      = 100;
   localparam int          CM_TIMEOUT_US = 1000;
   localparam int          CM_CYCLES    = CM_TIMEOUT_US * CLK_MHZ;
endpackage
`default_nettype wire

// ==== common/fault_if.sv ====
// carrier between the watchdog core and the fault pin stretcher
`timescale 1ns/1ns
`default_nettype none
interface fault_if;
   logic err_p;
   logic cm_err;
   logic pin_in;
   logic drive;
   logic busy;
   modport ctl     (output err_p, output cm_err, output pin_in, input drive, input busy);
   modport stretch (input err_p, input cm_err, input pin_in, output drive, output busy);
endinterface
`default_nettype wire

// ==== hdl/idle_tick_timer.sv ====
// free running idle counter with tap select and pending flag
`timescale 1ns/1ns
`default_nettype none
module idle_tick_timer
   import wdt_pkg::*;
#(
   parameter int CNT_W = IDL_CNT_W
) (
   // clock and resets
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       por_i,
   // control
   input  wire logic       tick_i,
   input  wire logic [2:0] tap_i,
   input  wire logic       clr_i,
   // status
   output logic            pend_o
);
   logic [CNT_W-1:0] idle_tick_counter_q;
   logic [CNT_W-1:0] cnt_d;
   logic [2:0]       tap;
   logic             toggle;

   assign tap    = (tap_i > TAP_MAX) ? TAP_MAX : tap_i;
   assign cnt_d  = idle_tick_counter_q + {{(CNT_W-1){1'b0}}, 1'b1};
   assign toggle = tick_i && (cnt_d[TAP_BASE + int'(tap)] != idle_tick_counter_q[TAP_BASE + int'(tap)]);

   // only power-on clears it; the ordinary reset leaves it running
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         idle_tick_counter_q <= '0;
      end else if (tick_i) begin
         idle_tick_counter_q <= cnt_d;
      end
   end

   // a toggle in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i || por_i) begin
         pend_o <= 1'b0;
      end else if (toggle) begin
         pend_o <= 1'b1;
      end else if (clr_i) begin
         pend_o <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== hdl/fault_stretch.sv ====
// open-drain fault pin driver with hold time after pin low
`timescale 1ns/1ns
`default_nettype none
module fault_stretch
   import wdt_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // core side
   fault_if.stretch  f
);
   typedef enum logic [1:0] {F_IDLE, F_PULL, F_HOLD, F_WAIT_HIGH} fstate_t;
   fstate_t    state_q;
   logic [4:0] hold_q;

   assign f.busy = (state_q != F_IDLE);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= F_IDLE;
         hold_q  <= '0;
         f.drive <= 1'b0;
      end else begin
         unique case (state_q)
            F_IDLE: begin
               if (f.err_p || f.cm_err) begin
                  state_q <= F_PULL;
                  f.drive <= 1'b1;
               end
            end
            F_PULL: begin
               // the hold only starts once the pin really reads low
               if (!f.pin_in) begin
                  state_q <= F_HOLD;
                  hold_q  <= '0;
               end
            end
            F_HOLD: begin
               if (f.cm_err) begin
                  hold_q <= '0;
               end else if (hold_q == FAULT_HOLD - 5'h01) begin
                  state_q <= F_WAIT_HIGH;
                  f.drive <= 1'b0;
               end else begin
                  hold_q <= hold_q + 5'h01;
               end
            end
            F_WAIT_HIGH: begin
               if (f.cm_err) begin
                  state_q <= F_PULL;
                  f.drive <= 1'b1;
               end else if (f.pin_in) begin
                  state_q <= F_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ==== bench/wdt_assertions.sv ====
// port assertions for the windowed watchdog top
`timescale 1ns/1ns
`default_nettype none
module wdt_assertions
   import wdt_pkg::*;
#(
   parameter int CM_LIMIT = CM_CYCLES
) (
   // clock and resets
   input wire logic       clk_i,
   input wire logic       rst_i,
   // register port
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic       wr_i,
   input wire logic       rd_i,
   input wire logic [7:0] rdata_o,
   // pins and flags
   input wire logic       tick_i,
   input wire logic       fault_pin_i,
   input wire logic       fault_pin_o,
   input wire logic       fault_pin_oe_o,
   input wire logic       idle_tick_pending_o
);
   // ----------------------------------------------------------
   // cycles the pin has been seen low during a fault
   // ----------------------------------------------------------
   logic [5:0] low_cnt_q;
   always_ff @(posedge clk_i) begin
      if (rst_i || !fault_pin_oe_o) begin
         low_cnt_q <= 6'h00;
      end else if (!fault_pin_i && low_cnt_q != 6'h3F) begin
         low_cnt_q <= low_cnt_q + 6'h01;
      end
   end
   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_drive_only_low : assert property (fault_pin_o == 1'b0)
      else $error("fault pin driven to a high level");
   a_release_after_hold : assert property ($fell(fault_pin_oe_o) |-> low_cnt_q >= 6'h10)
      else $error("fault released before minimum hold");
   a_hold_stays_low : assert property (fault_pin_oe_o && !fault_pin_i && low_cnt_q < 6'h0F |=> fault_pin_oe_o)
      else $error("fault dropped during hold");
   // busy lingers a cycle after the pin goes high, hence the look back
   a_bad_key_fault : assert property (wr_i && addr_i == OFF_SERVICE && wdata_i[5:1] != SVC_KEY
      && !fault_pin_oe_o && !$past(fault_pin_oe_o, 2) |-> ##2 fault_pin_oe_o)
      else $error("bad key service did not fault");
   a_key_reads_zero : assert property (rd_i && addr_i == OFF_SERVICE |=> rdata_o[5:1] == 5'h00)
      else $error("key field visible on read");
   a_rdata_one_cycle : assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data outside read cycle");
   a_reset_quiet : assert property ($fell(rst_i) |-> !fault_pin_oe_o && !idle_tick_pending_o)
      else $error("fault or pending set after reset");
   a_pend_stays_set : assert property (idle_tick_pending_o && !(wr_i && addr_i == OFF_IDLE_CTL && wdata_i[7])
      |=> idle_tick_pending_o)
      else $error("pending flag cleared by itself");
   a_pend_on_tick : assert property ($rose(idle_tick_pending_o) |-> $past(tick_i))
      else $error("pending flag set without a tick");
endmodule
bind windowed_watchdog_clock_monitor wdt_assertions #(.CM_LIMIT(CM_LIMIT)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .tick_i(tick_i), .fault_pin_i(fault_pin_i), .fault_pin_o(fault_pin_o),
   .fault_pin_oe_o(fault_pin_oe_o), .idle_tick_pending_o(idle_tick_pending_o));
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import wdt_pkg::*;
   // ----------------------------------------------------------
   // signals and counters
   // ----------------------------------------------------------
   logic       clk_i, rst_i, por_i, wr_i, rd_i, halt_i, idle_i, cm_run;
   logic       boot_entry_i, boot_exit_i, tick_i, inst_clk_i, fault_pin_i;
   logic       fault_pin_o, fault_pin_oe_o, idle_tick_pending_o;
   logic [3:0] addr_i;
   logic [7:0] wdata_i, rdata_o;
   int         mismatches, checks, cyc, n;
   // weak pull-up on the shared fault pin
   assign fault_pin_i = fault_pin_oe_o ? 1'b0 : 1'b1;
   windowed_watchdog_clock_monitor #(.CM_LIMIT(50)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .halt_i(halt_i), .idle_i(idle_i), .boot_entry_i(boot_entry_i),
      .boot_exit_i(boot_exit_i), .tick_i(tick_i), .inst_clk_i(inst_clk_i), .fault_pin_i(fault_pin_i),
      .fault_pin_o(fault_pin_o), .fault_pin_oe_o(fault_pin_oe_o), .idle_tick_pending_o(idle_tick_pending_o));
   // ----------------------------------------------------------
   // clock, monitored clock and timeout
   // ----------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      inst_clk_i <= cm_run ? ~inst_clk_i : inst_clk_i;
      if (cyc == 60000) begin
         mismatches = mismatches + 1;
         complete_run();
      end
   end
   // ----------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      if (mismatches == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic reset(input logic p);
      @(posedge clk_i);
      rst_i <= 1'b1;
      por_i <= p;
      halt_i <= 1'b0;
      idle_i <= 1'b0;
      cm_run <= 1'b1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 check(what, rdata_o, exp);
   endtask
   // wait on a level of oe or pending, bounded; n holds the cycles taken
   task automatic wait_for(input bit pend, input logic lvl, input int lim);
      n = 0;
      while ((pend ? idle_tick_pending_o : fault_pin_oe_o) !== lvl && n < lim) begin
         @(posedge clk_i);
         #1 n = n + 1;
      end
   endtask
   task automatic expect_fault(input string what);
      repeat (2) @(posedge clk_i);
      #1 check(what, fault_pin_oe_o, 1'b1);
      check("driven level", fault_pin_o, 1'b0);
      wait_for(1'b0, 1'b0, 100);
      check("fault hold", n >= 16 && n <= 34, 1'b1);
   endtask
   task automatic expect_quiet(input string what);
      repeat (3) @(posedge clk_i);
      #1 check(what, fault_pin_oe_o, 1'b0);
   endtask
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic s_reset_values();
      rd(OFF_SERVICE, 8'hC1, "service after reset");
      rd(OFF_STATUS, 8'h00, "status after reset");
      rd(4'hF, 8'h00, "unmapped read");
      wr(OFF_SERVICE, 8'hC1);
      // a good first service while the pin is pulled must leave nothing locked
      wr(OFF_SERVICE, 8'h18);
      expect_fault("bad first key");
      rd(OFF_STATUS, 8'h00, "service during fault ignored");
   endtask
   task automatic s_lock_and_early();
      reset(1'b0);
      wr(OFF_SERVICE, 8'h18);
      expect_quiet("first service inside lower limit");
      rd(OFF_SERVICE, 8'h00, "locked service value");
      rd(OFF_STATUS, 8'h0A, "status after first service");
      wr(OFF_SERVICE, 8'h18);
      expect_fault("service inside lower limit");
      repeat (2100) @(posedge clk_i);
      wr(OFF_SERVICE, 8'h99);
      expect_fault("mismatched later service");
      rd(OFF_SERVICE, 8'h00, "selection still locked");
   endtask
   task automatic s_halt_timeout();
      reset(1'b0);
      wr(OFF_SERVICE, 8'h18);
      halt_i <= 1'b1;
      repeat (9000) @(posedge clk_i);
      #1 check("fault during halt", fault_pin_oe_o, 1'b0);
      halt_i <= 1'b0;
      repeat (2100) @(posedge clk_i);
      wr(OFF_SERVICE, 8'h18);
      expect_quiet("service after halt");
      // no ticks for a while: the window must not advance meanwhile
      @(posedge clk_i);
      tick_i <= 1'b0;
      repeat (1000) @(posedge clk_i);
      tick_i <= 1'b1;
      wait_for(1'b0, 1'b1, 9000);
      check("upper limit timeout", n >= 8185 && n <= 8200, 1'b1);
   endtask
   task automatic s_idle_boot();
      reset(1'b0);
      wr(OFF_SERVICE, 8'h18);
      repeat (2100) @(posedge clk_i);
      idle_i <= 1'b1;
      repeat (100) @(posedge clk_i);
      idle_i <= 1'b0;
      wr(OFF_SERVICE, 8'h18);
      expect_fault("service right after idle exit");
      repeat (2100) @(posedge clk_i);
      wr(OFF_SERVICE, 8'h18);
      boot_entry_i <= 1'b1;
      @(posedge clk_i);
      boot_entry_i <= 1'b0;
      boot_exit_i <= 1'b1;
      @(posedge clk_i);
      boot_exit_i <= 1'b0;
      wr(OFF_SERVICE, 8'h18);
      expect_quiet("service right after boot exit");
   endtask
   task automatic s_clock_monitor();
      reset(1'b0);
      halt_i <= 1'b1;
      cm_run <= 1'b0;
      wait_for(1'b0, 1'b1, 200);
      check("stopped clock fault", n >= 40 && n <= 60, 1'b1);
      @(posedge clk_i);
      cm_run <= 1'b1;
      halt_i <= 1'b0;
      wait_for(1'b0, 1'b0, 200);
      check("fault release after clock back", n >= 16 && n <= 60, 1'b1);
   endtask
   task automatic s_idle_pending();
      reset(1'b0);
      wr(OFF_IDLE_CTL, 8'h80);
      wait_for(1'b1, 1'b1, 4200);
      check("pending within tap period", n <= 4100, 1'b1);
      rd(OFF_IDLE_CTL, 8'h80, "idle control with pending");
      wr(OFF_IDLE_CTL, 8'h80);
      rd(OFF_IDLE_CTL, 8'h00, "idle control after clear");
      repeat (2000) @(posedge clk_i);
      reset(1'b0);
      wait_for(1'b1, 1'b1, 4200);
      check("counter kept over reset", n < 3000, 1'b1);
   endtask
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      cyc = 0;
      mismatches = 0;
      checks = 0;
      rst_i = 1'b1;
      por_i = 1'b1;
      addr_i = 4'h0;
      wdata_i = 8'h00;
      wr_i = 1'b0;
      rd_i = 1'b0;
      halt_i = 1'b0;
      idle_i = 1'b0;
      boot_entry_i = 1'b0;
      boot_exit_i = 1'b0;
      tick_i = 1'b1;
      inst_clk_i = 1'b0;
      cm_run = 1'b1;
      reset(1'b1);
      s_reset_values();
      s_lock_and_early();
      s_halt_timeout();
      s_idle_boot();
      s_clock_monitor();
      s_idle_pending();
      complete_run();
   end
endmodule
`default_nettype wire
